// ---- rtl/tbsa_pkg.sv ----
/*
 package of the token bus slave adapter: register map, field layout,
 request codes, image sizes, indicator timing.
 assumes a 100 MHz clock and 32-bit ahb-lite register access.
*/
// Notes on behaviour
// - station number from six switches, 1 to 64
// - origin selector switches have no effect
// - respond only to requests addressed here
// - broadcast global data is never answered
// - read code 3 serves outgoing area
// - writes to outgoing area rejected, unchanged
// - codes 16 and 6 write incoming area
// - incoming area is readable by code 3
// - image at most 320 bytes, configurable smaller
// - up to 16 units, 6 or 20 bytes
// - normal operation: one flash every 160 ms
// - offline watch: one flash every second
// - idle: two flashes then 2 s dark
// - no other node: three flashes, 1.7 s
// - duplicate address: four flashes, 1.4 s
// - init indicator lit once initialised only
// - each register is two image bytes
package tbsa_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_INDEX = 8'h08;
  localparam logic [7:0] OFS_OUTD  = 8'h0c;
  localparam logic [7:0] OFS_IND   = 8'h10;

  // control fields
  localparam int CTRL_INIT  = 0;
  localparam int CTRL_ERR   = 1;
  localparam int CTRL_WIDE  = 2;
  localparam int CTRL_UNITS = 4;
  localparam int CTRL_WORDS = 16;
  localparam logic [31:0] CTRL_RESET = 32'h00a0_00f4;

  // status fields
  localparam int STAT_NET = 8;

  ////////////////////////////////////////////////////////////////////////
  // request codes
  localparam logic [7:0] FC_READ  = 8'h03;
  localparam logic [7:0] FC_WR1   = 8'h06;
  localparam logic [7:0] FC_WRN   = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;

  // register numbers 40001, 40161, 41025, 41185
  localparam logic [15:0] OUT_FIRST = 16'h9c41;
  localparam logic [15:0] OUT_LAST  = 16'h9ce1;
  localparam logic [15:0] IN_FIRST  = 16'ha041;
  localparam logic [15:0] IN_LAST   = 16'ha0e1;

  // image: 320 bytes, 160 words
  localparam int         IMG_WORDS = 160;
  localparam logic [8:0] IMG_LIM   = 9'h0a0;
  localparam logic [3:0] SLICE_NARROW = 4'h3;
  localparam logic [3:0] SLICE_WIDE   = 4'ha;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ  = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [11:0] FLASH_MS   = 12'h028;
  localparam logic [11:0] GAP_MS     = 12'h0c8;
  localparam logic [11:0] NORMAL_MS  = 12'h0a0;
  localparam logic [11:0] OFFLINE_MS = 12'h3e8;
  localparam logic [11:0] IDLE_MS    = 12'h7d0;
  localparam logic [11:0] LONELY_MS  = 12'h6a4;
  localparam logic [11:0] DUP_MS     = 12'h578;

  typedef enum logic [2:0] {
    NS_INIT, NS_NORMAL, NS_OFFLINE, NS_IDLE, NS_LONELY, NS_DUP
  } tbsa_net_e;

endpackage

// ---- rtl/tbsa_blink.sv ----
/*
 flash pattern generator for the activity indicator.
 assumes a one-cycle millisecond tick on the same clock.
*/
`timescale 1ns/1ps
module tbsa_blink (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              tick_ms,
  input  tbsa_pkg::tbsa_net_e    mode,
  output logic                   led
);

  logic [2:0]  flashes;
  logic [11:0] dark;
  logic [11:0] cnt;
  logic [2:0]  num;
  tbsa_pkg::tbsa_net_e last_mode;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    flashes = 3'h1;
    dark    = 12'h000;
    case (mode)
      tbsa_pkg::NS_NORMAL: dark = tbsa_pkg::NORMAL_MS - tbsa_pkg::FLASH_MS;
      tbsa_pkg::NS_OFFLINE: dark = tbsa_pkg::OFFLINE_MS - tbsa_pkg::FLASH_MS;
      tbsa_pkg::NS_IDLE: begin
        flashes = 3'h2;
        dark    = tbsa_pkg::IDLE_MS;
      end
      tbsa_pkg::NS_LONELY: begin
        flashes = 3'h3;
        dark    = tbsa_pkg::LONELY_MS;
      end
      tbsa_pkg::NS_DUP: begin
        flashes = 3'h4;
        dark    = tbsa_pkg::DUP_MS;
      end
      default: flashes = 3'h0;
    endcase
  end

  // a mode change restarts the pattern so bursts are never mixed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led       <= 1'b0;
      cnt       <= 12'h000;
      num       <= 3'h0;
      last_mode <= tbsa_pkg::NS_INIT;
    end else if (mode != last_mode || flashes == 3'h0) begin
      last_mode <= mode;
      led       <= 1'b0;
      cnt       <= 12'h000;
      num       <= 3'h0;
    end else if (tick_ms) begin
      if (cnt != 12'h000) begin
        cnt <= cnt - 12'h001;
      end else if (led) begin
        led <= 1'b0;
        num <= num + 3'h1;
        cnt <= (num + 3'h1 >= flashes) ? dark - 12'h001 : tbsa_pkg::GAP_MS - 12'h001;
      end else begin
        led <= 1'b1;
        cnt <= tbsa_pkg::FLASH_MS - 12'h001;
        if (num >= flashes) begin
          num <= 3'h0;
        end
      end
    end
  end

endmodule

// ---- rtl/tbsa_top.sv ----
/*
 token bus slave adapter: register responder for the fieldbus,
 two word images, ahb-lite control port, health indicators.
 assumes requests come one at a time from same-clock link logic,
 switches are asynchronous pins.
*/
`timescale 1ns/1ps
module tbsa_top #(
  parameter int TICK_CYC = tbsa_pkg::TICK_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [5:0]        station_switches_open,
  input  wire logic [3:0]        origin_selector_switches,
  input  tbsa_pkg::tbsa_net_e    net_state,
  input  wire logic              req_valid,
  input  wire logic [6:0]        req_node,
  input  wire logic              req_global,
  input  wire logic [7:0]        req_func,
  input  wire logic [15:0]       req_reg,
  input  wire logic [15:0]       req_wdata,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_func,
  output logic [15:0]            rsp_data,
  output logic [6:0]             station_number,
  output logic                   activity_indicator,
  output logic                   init_done_indicator,
  output logic                   error_indicator
);

  ////////////////////////////////////////////////////////////////////////
  // area hit: register inside the area and below the image limit
  function automatic logic area_hit(
    input logic [15:0] regn,
    input logic [15:0] first,
    input logic [15:0] last,
    input logic [8:0]  lim
  );
    logic [15:0] off;
    off = regn - first;
    area_hit = (regn >= first) && (regn <= last) && (off < {7'h00, lim});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // switch synchroniser
  logic [5:0] sw_meta;
  logic [5:0] sw_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_meta <= 6'h00;
      sw_sync <= 6'h00;
    end else begin
      sw_meta <= station_switches_open;
      sw_sync <= sw_meta;
    end
  end

  // open switches give address minus one, switch 1 in bit 5
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      station_number <= 7'h01;
    end else begin
      station_number <= {1'b0, sw_sync} + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [16:0] div_cnt;
  logic        tick_ms;

  assign tick_ms = (div_cnt == 17'(TICK_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 17'h00000;
    end else if (tick_ms) begin
      div_cnt <= 17'h00000;
    end else begin
      div_cnt <= div_cnt + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic [31:0] ctrl;
  logic [7:0]  img_index;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        ap_take;
  logic        wr_ctrl;
  logic        wr_index;
  logic        wr_outd;
  logic        idx_ok;
  logic [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel & htrans[1] & hready;
  assign wr_ctrl   = dp_wr & (dp_addr == tbsa_pkg::OFS_CTRL);
  assign wr_index  = dp_wr & (dp_addr == tbsa_pkg::OFS_INDEX);
  assign wr_outd   = dp_wr & (dp_addr == tbsa_pkg::OFS_OUTD) & idx_ok;
  assign idx_ok    = ({1'b0, img_index} < tbsa_pkg::IMG_LIM);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= ap_take & hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= tbsa_pkg::CTRL_RESET;
      img_index <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata;
      end
      if (wr_index) begin
        img_index <= hwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // image limit from configured size and attached units
  logic       ctrl_wide;
  logic [3:0] ctrl_units;
  logic [8:0] cfg_words;
  logic [3:0] slice_words;
  logic [8:0] unit_words;
  logic [8:0] small_lim;
  logic [8:0] img_lim;

  assign ctrl_wide   = ctrl[tbsa_pkg::CTRL_WIDE];
  assign ctrl_units  = ctrl[tbsa_pkg::CTRL_UNITS +: 4];
  assign cfg_words   = {1'b0, ctrl[tbsa_pkg::CTRL_WORDS +: 8]};
  assign slice_words = ctrl_wide ? tbsa_pkg::SLICE_WIDE : tbsa_pkg::SLICE_NARROW;
  assign unit_words  = 9'(({5'h00, ctrl_units} + 9'h001) * {5'h00, slice_words});
  assign small_lim   = (cfg_words < unit_words) ? cfg_words : unit_words;
  assign img_lim     = (small_lim < tbsa_pkg::IMG_LIM) ? small_lim : tbsa_pkg::IMG_LIM;

  ////////////////////////////////////////////////////////////////////////
  // fieldbus request decode
  logic        accept;
  logic        is_read;
  logic        is_write;
  logic        hit_out;
  logic        hit_in;
  logic        ok_read;
  logic        ok_write;
  logic [7:0]  out_idx;
  logic [7:0]  in_idx;
  logic [7:0]  exc_code;
  logic [15:0] rd_word;
  logic [15:0] next_rsp_data;
  logic [7:0]  next_rsp_func;

  // nothing is ever sent unasked; broadcast data is dropped silently
  assign accept   = req_valid & ~req_global & (req_node == station_number);
  assign is_read  = (req_func == tbsa_pkg::FC_READ);
  assign is_write = (req_func == tbsa_pkg::FC_WR1) | (req_func == tbsa_pkg::FC_WRN);
  assign hit_out  = area_hit(req_reg, tbsa_pkg::OUT_FIRST, tbsa_pkg::OUT_LAST, img_lim);
  assign hit_in   = area_hit(req_reg, tbsa_pkg::IN_FIRST, tbsa_pkg::IN_LAST, img_lim);
  assign out_idx  = 8'(req_reg - tbsa_pkg::OUT_FIRST);
  assign in_idx   = 8'(req_reg - tbsa_pkg::IN_FIRST);
  assign ok_read  = is_read & (hit_out | hit_in);
  assign ok_write = is_write & hit_in;
  assign exc_code = (is_read | is_write) ? tbsa_pkg::EXC_ADDR : tbsa_pkg::EXC_FUNC;

  ////////////////////////////////////////////////////////////////////////
  // images: one 16-bit word per register, high byte first
  logic [15:0] out_mem [0:tbsa_pkg::IMG_WORDS-1];
  logic [15:0] in_mem  [0:tbsa_pkg::IMG_WORDS-1];

  genvar gi;
  generate
    for (gi = 0; gi < tbsa_pkg::IMG_WORDS; gi++) begin : g_word
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          out_mem[gi] <= 16'h0000;
          in_mem[gi]  <= 16'h0000;
        end else begin
          // only software writes the outgoing image
          if (wr_outd && img_index == 8'(gi)) begin
            out_mem[gi] <= hwdata[15:0];
          end
          if (accept && ok_write && in_idx == 8'(gi)) begin
            in_mem[gi] <= req_wdata;
          end
        end
      end
    end
  endgenerate

  assign rd_word = hit_out ? out_mem[out_idx] : in_mem[in_idx];

  always_comb begin
    next_rsp_func = req_func | tbsa_pkg::EXC_FLAG;
    next_rsp_data = {8'h00, exc_code};
    if (ok_read) begin
      next_rsp_func = req_func;
      next_rsp_data = rd_word;
    end else if (ok_write) begin
      next_rsp_func = req_func;
      next_rsp_data = req_wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_valid <= 1'b0;
      rsp_func  <= 8'h00;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= accept;
      if (accept) begin
        rsp_func <= next_rsp_func;
        rsp_data <= next_rsp_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux, sampled in the address phase
  logic [31:0] rd_stat;
  logic [15:0] rd_outd;
  logic [15:0] rd_ind;

  assign rd_stat = {21'h000000, net_state, 1'b0, station_number};
  assign rd_outd = idx_ok ? out_mem[img_index] : 16'h0000;
  assign rd_ind  = idx_ok ? in_mem[img_index] : 16'h0000;

  // a read right after a write to the same register sees the old value
  assign rd_mux = (haddr[7:0] == tbsa_pkg::OFS_CTRL)  ? ctrl :
                  (haddr[7:0] == tbsa_pkg::OFS_STAT)  ? rd_stat :
                  (haddr[7:0] == tbsa_pkg::OFS_INDEX) ? {24'h000000, img_index} :
                  (haddr[7:0] == tbsa_pkg::OFS_OUTD)  ? {16'h0000, rd_outd} :
                  (haddr[7:0] == tbsa_pkg::OFS_IND)   ? {16'h0000, rd_ind} :
                  32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicators
  logic comm_fail;

  assign comm_fail = ctrl[tbsa_pkg::CTRL_ERR] | (net_state == tbsa_pkg::NS_LONELY) |
                     (net_state == tbsa_pkg::NS_DUP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_done_indicator <= 1'b0;
      error_indicator     <= 1'b0;
    end else begin
      init_done_indicator <= ctrl[tbsa_pkg::CTRL_INIT] & (net_state != tbsa_pkg::NS_INIT);
      error_indicator     <= comm_fail;
    end
  end

  tbsa_blink u_blink (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick_ms (tick_ms),
    .mode    (net_state),
    .led     (activity_indicator)
  );

endmodule

// ---- testbench/tbsa_assertions.sv ----
/*
 checker: fieldbus answers, station number, init and error lights.
 assumes it is bound to tbsa_top and sees only its ports.
*/
`timescale 1ns/1ps
module tbsa_assertions (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic [5:0]     station_switches_open,
  input tbsa_pkg::tbsa_net_e net_state,
  input wire logic           req_valid,
  input wire logic [6:0]     req_node,
  input wire logic           req_global,
  input wire logic [7:0]     req_func,
  input wire logic [15:0]    req_reg,
  input wire logic           rsp_valid,
  input wire logic [7:0]     rsp_func,
  input wire logic [15:0]    rsp_data,
  input wire logic [6:0]     station_number,
  input wire logic           init_done_indicator,
  input wire logic           error_indicator
);
  logic [2:0] up_cnt;
  wire taken  = req_valid && !req_global && req_node == station_number;
  wire fc_ok  = req_func inside {tbsa_pkg::FC_READ, tbsa_pkg::FC_WR1, tbsa_pkg::FC_WRN};
  wire in_out = req_reg >= tbsa_pkg::OUT_FIRST && req_reg <= tbsa_pkg::OUT_LAST;
  wire bad_st = net_state inside {tbsa_pkg::NS_LONELY, tbsa_pkg::NS_DUP};

  // edges since reset, so $past never reaches back into reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_taken;
    taken;
  endsequence
  sequence s_bad_fc;
    taken && !fc_ok;
  endsequence
  sequence s_out_wr;
    taken && fc_ok && req_func != tbsa_pkg::FC_READ && in_out;
  endsequence

  a_answer_next: assert property (s_taken |=> rsp_valid)
    else $error("request not answered next cycle");
  a_no_unasked: assert property (rsp_valid |-> $past(taken))
    else $error("answer without own request");
  a_global_quiet: assert property (req_valid && req_global |=> !rsp_valid)
    else $error("global request answered");
  a_bad_func: assert property (s_bad_fc |=> rsp_func == ($past(req_func) | tbsa_pkg::EXC_FLAG)
    && rsp_data == {8'h00, tbsa_pkg::EXC_FUNC})
    else $error("bad function not refused");
  a_out_locked: assert property (s_out_wr |=> rsp_func[7] && rsp_data == {8'h00, tbsa_pkg::EXC_ADDR})
    else $error("write to outgoing area accepted");
  a_station_map: assert property (up_cnt == 3'h7 |->
    station_number == {1'b0, $past(station_switches_open, 3)} + 7'h01)
    else $error("station number wrong");
  a_init_dark: assert property (up_cnt != 3'h0 && $past(net_state) == tbsa_pkg::NS_INIT
    |-> !init_done_indicator)
    else $error("init light on before init");
  a_error_lit: assert property (up_cnt != 3'h0 && $past(bad_st) |-> error_indicator)
    else $error("error light off in failure");
endmodule

bind tbsa_top tbsa_assertions u_tbsa_assertions (
  .hclk(hclk), .hresetn(hresetn), .station_switches_open(station_switches_open),
  .net_state(net_state), .req_valid(req_valid), .req_node(req_node), .req_global(req_global),
  .req_func(req_func), .req_reg(req_reg), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
  .rsp_data(rsp_data), .station_number(station_number),
  .init_done_indicator(init_done_indicator), .error_indicator(error_indicator));

// ---- testbench/tbsa_fb_master.sv ----
/*
 fieldbus master model: one request at a time, answer read at the
 second edge. assumes the adapter's clock.
*/
`timescale 1ns/1ps
module tbsa_fb_master (
  input  wire logic        hclk,
  output logic             req_valid,
  output logic [6:0]       req_node,
  output logic             req_global,
  output logic [7:0]       req_func,
  output logic [15:0]      req_reg,
  output logic [15:0]      req_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_func,
  input  wire logic [15:0] rsp_data
);
  initial begin
    req_valid = 1'b0;
    {req_node, req_global, req_func, req_reg, req_wdata} = 48'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // gap idles first, so the master is prompt or slow
  task automatic request(input int gap, input logic [6:0] n, input logic g, input logic [7:0] f,
                         input logic [15:0] r, input logic [15:0] d, output logic got,
                         output logic [7:0] rf, output logic [15:0] rd);
    repeat (gap) @(posedge hclk);
    req_valid <= 1'b1;
    {req_node, req_global, req_func, req_reg, req_wdata} <= {n, g, f, r, d};
    @(posedge hclk);
    req_valid <= 1'b0;
    // released fields show the inverse, never a stale copy
    {req_node, req_global, req_func, req_reg, req_wdata} <= ~{n, g, f, r, d};
    @(posedge hclk);
    got = rsp_valid;
    rf = rsp_func;
    rd = rsp_data;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
/*
 testbench of the adapter: ahb-lite tasks, fieldbus master model,
 random and corner requests, light timing on a short tick.
 assumes a tick of 10 cycles per millisecond.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int TICK = 10;
  logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata, rd, wd;
  logic [5:0]          sw = 6'h00;
  logic [3:0]          origin = 4'h0;
  tbsa_pkg::tbsa_net_e net_state = tbsa_pkg::NS_INIT;
  logic                hreadyout, hresp, req_valid, req_global, rsp_valid, act, init_led, err_led, got;
  logic [6:0]          req_node, station_number, stn;
  logic [7:0]          req_func, rsp_func, gf, wf, idx;
  logic [15:0]         req_reg, req_wdata, rsp_data, gd;
  int                  seed, len, i, failures = 0, tests_run = 0, cycles = 0;
  logic [7:0]          bad_fc [8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h0f, 8'h16, 8'h17};
  logic [15:0]         bad_rg [4] = '{16'h9c40, 16'h9ce1, 16'ha040, 16'ha0e1};
  logic [31:0]         cfg [3] = '{32'h0014_0004, 32'h00c8_00f0, 32'h0007_0034};
  tbsa_pkg::tbsa_net_e modes [5] = '{tbsa_pkg::NS_NORMAL, tbsa_pkg::NS_OFFLINE,
                                     tbsa_pkg::NS_IDLE, tbsa_pkg::NS_LONELY, tbsa_pkg::NS_DUP};
  int                  dark [5] = '{tbsa_pkg::NORMAL_MS - tbsa_pkg::FLASH_MS,
                                    tbsa_pkg::OFFLINE_MS - tbsa_pkg::FLASH_MS,
                                    tbsa_pkg::IDLE_MS, tbsa_pkg::LONELY_MS, tbsa_pkg::DUP_MS};
  wire                 hready = hreadyout;

  tbsa_top #(.TICK_CYC(TICK)) u_tbsa_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .station_switches_open(sw), .origin_selector_switches(origin),
    .net_state(net_state), .req_valid(req_valid), .req_node(req_node), .req_global(req_global),
    .req_func(req_func), .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_func(rsp_func), .rsp_data(rsp_data), .station_number(station_number),
    .activity_indicator(act), .init_done_indicator(init_led), .error_indicator(err_led));
  tbsa_fb_master u_tbsa_fb_master (
    .hclk(hclk), .req_valid(req_valid), .req_node(req_node), .req_global(req_global),
    .req_func(req_func), .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_func(rsp_func), .rsp_data(rsp_data));

  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] exp_station(input logic [5:0] s);
    return {1'b0, s} + 7'h01;
  endfunction
  function automatic int lim_of(input logic [31:0] c);
    int u;
    u = (c[7:4] + 1) * (c[2] ? tbsa_pkg::SLICE_WIDE : tbsa_pkg::SLICE_NARROW);
    if (c[23:16] < u)
      u = c[23:16];
    return (u < tbsa_pkg::IMG_WORDS) ? u : tbsa_pkg::IMG_WORDS;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // tick phase may shift a pattern by one tick
  task automatic chk_len(input string nm, input int e, input int g);
    tests_run++;
    if (g < e - TICK - 2 || g > e + TICK + 2) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic fb(input logic [7:0] f, input logic [15:0] r, input logic [15:0] d,
                    input logic [7:0] ef, input logic [15:0] ed);
    u_tbsa_fb_master.request($random(seed) & 1, stn, 1'b0, f, r, d, got, gf, gd);
    chk("answered", 32'h1, {31'h0, got});
    chk("rsp_func", {24'h0, ef}, {24'h0, gf});
    chk("rsp_data", {16'h0, ed}, {16'h0, gd});
  endtask
  task automatic blink(input int n, output int len);
    len = 0;
    repeat (n) begin
      while (act !== 1'b0) @(posedge hclk);
      while (act !== 1'b1) @(posedge hclk);
    end
    while (act !== 1'b0) @(posedge hclk);
    while (act !== 1'b1) begin
      len++;
      @(posedge hclk);
    end
  endtask
  task automatic finish_test;
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 97966;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, tbsa_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", tbsa_pkg::CTRL_RESET, rd);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (i = 0; i < 6; i++) begin
      sw <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      origin <= 4'($random(seed));
      repeat (4) @(posedge hclk);
      chk("station", {25'h0, exp_station(sw)}, {25'h0, station_number});
    end
    stn = exp_station(sw);
    ahb(1'b0, tbsa_pkg::OFS_STAT, 32'h0);
    chk("status", {21'h0, net_state, 1'b0, stn}, rd);
    $display("station test done");
    for (i = 0; i < 8; i++) begin
      idx = (i == 0) ? 8'h00 : (i == 1) ? 8'h9f : 8'($random(seed) & 8'h7f);
      wd = $random(seed);
      wf = i[0] ? tbsa_pkg::FC_WRN : tbsa_pkg::FC_WR1;
      ahb(1'b1, tbsa_pkg::OFS_INDEX, {24'h0, idx});
      ahb(1'b1, tbsa_pkg::OFS_OUTD, wd);
      fb(tbsa_pkg::FC_READ, tbsa_pkg::OUT_FIRST + idx, 16'h0, tbsa_pkg::FC_READ, wd[15:0]);
      fb(wf, tbsa_pkg::OUT_FIRST + idx, ~wd[15:0], wf | 8'h80, 16'h0002);
      fb(tbsa_pkg::FC_READ, tbsa_pkg::OUT_FIRST + idx, 16'h0, tbsa_pkg::FC_READ, wd[15:0]);
      fb(wf, tbsa_pkg::IN_FIRST + idx, wd[31:16], wf, wd[31:16]);
      fb(tbsa_pkg::FC_READ, tbsa_pkg::IN_FIRST + idx, 16'h0, tbsa_pkg::FC_READ, wd[31:16]);
      ahb(1'b0, tbsa_pkg::OFS_IND, 32'h0);
      chk("incoming", {16'h0, wd[31:16]}, {16'h0, rd[15:0]});
      ahb(1'b0, tbsa_pkg::OFS_INDEX, 32'h0);
      chk("index", {24'h0, idx}, rd);
      ahb(1'b0, tbsa_pkg::OFS_OUTD, 32'h0);
      chk("outgoing", {16'h0, wd[15:0]}, rd);
    end
    $display("image test done");
    foreach (bad_fc[k]) fb(bad_fc[k], tbsa_pkg::OUT_FIRST, 16'h0, bad_fc[k] | 8'h80, 16'h0001);
    foreach (bad_rg[k]) fb(tbsa_pkg::FC_READ, bad_rg[k], 16'h0, 8'h83, 16'h0002);
    u_tbsa_fb_master.request(0, stn + 7'h01, 1'b0, tbsa_pkg::FC_READ, tbsa_pkg::OUT_FIRST, 16'h0, got, gf, gd);
    chk("other node", 32'h0, {31'h0, got});
    u_tbsa_fb_master.request(0, stn, 1'b1, tbsa_pkg::FC_WRN, tbsa_pkg::IN_FIRST, 16'h0, got, gf, gd);
    chk("global", 32'h0, {31'h0, got});
    foreach (cfg[k]) begin
      ahb(1'b1, tbsa_pkg::OFS_CTRL, cfg[k]);
      len = lim_of(cfg[k]);
      u_tbsa_fb_master.request(0, stn, 1'b0, 8'h03, tbsa_pkg::OUT_FIRST + 16'(len - 1), 16'h0, got, gf, gd);
      chk("in limit", 32'h3, {24'h0, gf});
      fb(8'h10, tbsa_pkg::IN_FIRST + 16'(len), 16'h0, 8'h90, 16'h0002);
    end
    $display("refusal test done");
    net_state <= tbsa_pkg::NS_NORMAL;
    ahb(1'b1, tbsa_pkg::OFS_CTRL, tbsa_pkg::CTRL_RESET | 32'h3);
    repeat (2) @(posedge hclk);
    chk("init led", 32'h1, {31'h0, init_led});
    chk("error led", 32'h1, {31'h0, err_led});
    ahb(1'b1, tbsa_pkg::OFS_CTRL, tbsa_pkg::CTRL_RESET | 32'h1);
    repeat (2) @(posedge hclk);
    chk("error led", 32'h0, {31'h0, err_led});
    foreach (modes[k]) begin
      net_state <= modes[k];
      @(posedge hclk);
      blink(k < 2 ? 1 : k, len);
      chk_len("dark", dark[k] * TICK, len);
    end
    chk("error led", 32'h1, {31'h0, err_led});
    net_state <= tbsa_pkg::NS_INIT;
    repeat (3) @(posedge hclk);
    chk("init led", 32'h0, {31'h0, init_led});
    $display("light test done");
    finish_test();
  end
endmodule
